// file: verilog/arsq_pkg.sv
// Register map, field layout, conversion timing and state types of the converter sequencer.
// What this block does
// - Repeat mode with start bit converts the selected channel again and again.
// - Start bit clears itself once a conversion begins.
// - Each completion not discarded or stopped stores result, sets end flag, pulses done interrupt.
// - Repeat mode begins the next conversion in the same cycle as the done interrupt.
// - Completion between low and high result reads is discarded, no interrupt.
// - Writing disable mode halts a conversion at once, partial result dropped.
// - Busy sets at conversion start; in repeat only disable or low power clears it.
// - Disable mode stops single conversions and repeat operation alike.
// - Disable mode zeroes end flag, busy flag and both result registers.
// - Single mode plus start bit launches exactly one conversion immediately.
// - Reading the high result register clears the end flag.
// - New start before high read clears end flag, old result kept.
// - Repeat conversions always use the channel select field.
// - Single mode gives one conversion; busy clears when it completes.
// - Time field picks 39, 78, 156, 312 or 624 cycles; rest reserved.
// - Low-power entry clears end flag and busy flag.
// - Ten-bit result: low register bits 7..0, high register bits 9..8.
package arsq_pkg;
	localparam int         ADDR_W      = 12;
	localparam logic [7:0] IDX_CTRL1   = 8'h34;
	localparam logic [7:0] IDX_CTRL2   = 8'h35;
	localparam logic [7:0] IDX_RES_LO  = 8'h36;
	localparam logic [7:0] IDX_RES_HI  = 8'h37;
	localparam int         IDX_LSB     = 2;
	localparam int         CH_LSB      = 0;
	localparam int         CH_W        = 4;
	localparam int         AIN_BIT     = 4;
	localparam int         MODE_LSB    = 5;
	localparam int         MODE_W      = 2;
	localparam int         START_BIT   = 7;
	localparam int         CT_LSB      = 0;
	localparam int         CT_W        = 3;
	localparam int         BUSY_BIT    = 6;
	localparam int         END_OF_CONVERSION_FLAG_BIT    = 7;
	localparam int         RES_W       = 10;
	localparam int         RES_LO_W    = 8;
	localparam int         RES_HI_W    = 2;
	localparam int         CNT_W       = 10;
	localparam logic [1:0] MODE_DIS    = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] CT_39       = 3'h0;
	localparam logic [2:0] CT_78       = 3'h1;
	localparam logic [2:0] CT_156      = 3'h2;
	localparam logic [2:0] CT_312      = 3'h3;
	localparam logic [9:0] CYC_39      = 10'h027;
	localparam logic [9:0] CYC_78      = 10'h04e;
	localparam logic [9:0] CYC_156     = 10'h09c;
	localparam logic [9:0] CYC_312     = 10'h138;
	localparam logic [9:0] CYC_624     = 10'h270;
	// The timer needs one cycle to load and one to register its done pulse.
	localparam logic [9:0] CNT_ADJ     = 10'h002;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_CONV = 2'h2
	} arsq_state_e;

	typedef struct packed {
		logic             start;
		logic             abort;
		logic [CNT_W-1:0] cycles;
	} arsq_tmr_req_s;

	typedef struct packed {
		logic             run;
		logic [CNT_W-1:0] cnt;
		logic             done;
	} arsq_tmr_s;

	typedef struct packed {
		arsq_state_e       state;
		logic [CH_W-1:0]   chan;
		logic              ain_en;
		logic [MODE_W-1:0] mode;
		logic              start;
		logic [CT_W-1:0]   ctime;
		logic              end_of_conversion_flag;
		logic              busy;
		logic [RES_W-1:0]  res;
		logic              low_pend;
		logic              awrdy;
		logic              wrdy;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [7:0]        wdata;
		logic              wstb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arrdy;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              irq;
		logic              conv_start;
		logic              conv_abort;
	} arsq_main_s;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr[IDX_LSB +: 8] == idx) && (addr[ADDR_W-1:IDX_LSB+8] == '0);
	endfunction : reg_hit

	// Reserved encodings fall back to the longest time so a mistake never shortens sampling.
	function automatic logic [CNT_W-1:0] conv_cycles(input logic [CT_W-1:0] sel);
		case (sel)
			CT_39:   conv_cycles = CYC_39;
			CT_78:   conv_cycles = CYC_78;
			CT_156:  conv_cycles = CYC_156;
			CT_312:  conv_cycles = CYC_312;
			default: conv_cycles = CYC_624;
		endcase
	endfunction : conv_cycles
endpackage : arsq_pkg

// file: verilog/arsq_conv_timer.sv
// Conversion time counter that paces each conversion of the analog core.
`timescale 1ns/100ps
module arsq_conv_timer (
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	input  wire arsq_pkg::arsq_tmr_req_s i_req,
	output logic                         o_done
);
	arsq_pkg::arsq_tmr_s s;
	arsq_pkg::arsq_tmr_s n;

	always_comb begin
		n = s;
		n.done = 1'b0;
		if (s.run) begin
			if (s.cnt == '0) begin
				n.run = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = s.cnt - 10'h001;
			end
		end
		if (i_req.start) begin
			n.run = 1'b1;
			n.cnt = i_req.cycles - arsq_pkg::CNT_ADJ;
		end
		if (i_req.abort) begin
			n.run = 1'b0;
			n.done = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_done = s.done;
endmodule : arsq_conv_timer

// file: verilog/arsq_top.sv
// Converter sequencer with its AXI4-Lite register slave.
`timescale 1ns/100ps
module arsq_top (
	input  wire logic                        I_CLK,
	input  wire logic                        I_RST,
	input  wire logic [arsq_pkg::ADDR_W-1:0] I_AWADDR,
	input  wire logic                        I_AWVALID,
	output logic                             O_AWREADY,
	input  wire logic [31:0]                 I_WDATA,
	input  wire logic [3:0]                  I_WSTRB,
	input  wire logic                        I_WVALID,
	output logic                             O_WREADY,
	output logic [1:0]                       O_BRESP,
	output logic                             O_BVALID,
	input  wire logic                        I_BREADY,
	input  wire logic [arsq_pkg::ADDR_W-1:0] I_ARADDR,
	input  wire logic                        I_ARVALID,
	output logic                             O_ARREADY,
	output logic [31:0]                      O_RDATA,
	output logic [1:0]                       O_RRESP,
	output logic                             O_RVALID,
	input  wire logic                        I_RREADY,
	input  wire logic [arsq_pkg::RES_W-1:0]  I_CONV_DATA,
	input  wire logic                        I_LOW_POWER,
	output logic [arsq_pkg::CH_W-1:0]        O_CHANNEL_SEL,
	output logic                             O_AIN_EN,
	output logic                             O_CONV_BUSY,
	output logic                             O_CONV_START,
	output logic                             O_CONV_ABORT,
	output logic                             O_DONE_IRQ
);
	// Every field is listed so a state bit added later cannot go without a reset value.
	localparam arsq_pkg::arsq_main_s RESET_STATE = '{
		state:      arsq_pkg::ST_IDLE,
		chan:       '0,
		ain_en:     1'h0,
		mode:       arsq_pkg::MODE_DIS,
		start:      1'h0,
		ctime:      '0,
		end_of_conversion_flag:       1'h0,
		busy:       1'h0,
		res:        '0,
		low_pend:   1'h0,
		awrdy:      1'h0,
		wrdy:       1'h0,
		aw_got:     1'h0,
		w_got:      1'h0,
		awaddr:     '0,
		wdata:      '0,
		wstb:       1'h0,
		bvalid:     1'h0,
		bresp:      arsq_pkg::RESP_OKAY,
		arrdy:      1'h0,
		rvalid:     1'h0,
		rdata:      '0,
		rresp:      arsq_pkg::RESP_OKAY,
		irq:        1'h0,
		conv_start: 1'h0,
		conv_abort: 1'h0
	};

	arsq_pkg::arsq_main_s    s;
	arsq_pkg::arsq_main_s    n;
	arsq_pkg::arsq_tmr_req_s tmr_req;
	logic                    tmr_done;
	logic                    wr_go;
	logic                    dis_wr;
	logic                    lo_rd;
	logic                    hi_rd;
	logic                    stop;
	logic                    mode_ok;

	arsq_conv_timer u_timer (
		.i_clk  (I_CLK),
		.i_rst  (I_RST),
		.i_req  (tmr_req),
		.o_done (tmr_done)
	);

	// The mode field is decoded to store it and to spot a disable write in the same cycle.
	function automatic logic [arsq_pkg::MODE_W-1:0] wr_mode(input logic [7:0] d);
		wr_mode = d[arsq_pkg::MODE_LSB +: arsq_pkg::MODE_W];
	endfunction : wr_mode

	// Mode 10 is neither single nor repeat, so a start there is ignored as in disable.
	function automatic logic mode_runs(input logic [arsq_pkg::MODE_W-1:0] m);
		mode_runs = (m == arsq_pkg::MODE_SINGLE) || (m == arsq_pkg::MODE_REPEAT);
	endfunction : mode_runs

	function automatic logic [31:0] ctrl1_image(input arsq_pkg::arsq_main_s st);
		ctrl1_image = '0;
		ctrl1_image[arsq_pkg::CH_LSB +: arsq_pkg::CH_W] = st.chan;
		ctrl1_image[arsq_pkg::AIN_BIT] = st.ain_en;
		ctrl1_image[arsq_pkg::MODE_LSB +: arsq_pkg::MODE_W] = st.mode;
		ctrl1_image[arsq_pkg::START_BIT] = st.start;
	endfunction : ctrl1_image

	function automatic logic [31:0] ctrl2_image(input arsq_pkg::arsq_main_s st);
		ctrl2_image = '0;
		ctrl2_image[arsq_pkg::CT_LSB +: arsq_pkg::CT_W] = st.ctime;
		ctrl2_image[arsq_pkg::BUSY_BIT] = st.busy;
		ctrl2_image[arsq_pkg::END_OF_CONVERSION_FLAG_BIT] = st.end_of_conversion_flag;
	endfunction : ctrl2_image

	function automatic logic [31:0] result_image(input logic [arsq_pkg::RES_W-1:0] res, input logic high);
		result_image = '0;
		if (high) begin
			result_image[arsq_pkg::RES_HI_W-1:0] = res[arsq_pkg::RES_W-1:arsq_pkg::RES_LO_W];
		end else begin
			result_image[arsq_pkg::RES_LO_W-1:0] = res[arsq_pkg::RES_LO_W-1:0];
		end
	endfunction : result_image

	always_comb begin
		n = s;
		n.irq = 1'b0;
		n.conv_start = 1'b0;
		n.conv_abort = 1'b0;
		wr_go = 1'b0;
		dis_wr = 1'b0;
		lo_rd = 1'b0;
		hi_rd = 1'b0;
		tmr_req = '0;
		// The timer only loads the time at a start, so a change mid-conversion waits for the next one.
		tmr_req.cycles = arsq_pkg::conv_cycles(s.ctime);

		// A refused start still clears, so it cannot fire later on its own.
		// start self clear
		if (s.start) begin
			n.start = 1'b0;
		end

		// Address and data are taken independently, in either order.
		if (I_AWVALID && s.awrdy) begin
			n.aw_got = 1'b1;
			n.awaddr = I_AWADDR;
		end
		if (I_WVALID && s.wrdy) begin
			n.w_got = 1'b1;
			n.wdata = I_WDATA[7:0];
			n.wstb = I_WSTRB[0];
		end
		// The response stands until the master takes it.
		if (s.bvalid && I_BREADY) begin
			n.bvalid = 1'b0;
		end

		// The response register must be free before a write lands, so one write stays outstanding.
		wr_go = s.aw_got && s.w_got && !s.bvalid;
		if (wr_go) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = arsq_pkg::RESP_OKAY;
			if (arsq_pkg::reg_hit(s.awaddr, arsq_pkg::IDX_CTRL1)) begin
				if (s.wstb) begin
					n.chan = s.wdata[arsq_pkg::CH_LSB +: arsq_pkg::CH_W];
					n.ain_en = s.wdata[arsq_pkg::AIN_BIT];
					n.mode = wr_mode(s.wdata);
					n.start = s.wdata[arsq_pkg::START_BIT];
					dis_wr = (wr_mode(s.wdata) == arsq_pkg::MODE_DIS);
				end
			end else if (arsq_pkg::reg_hit(s.awaddr, arsq_pkg::IDX_CTRL2)) begin
				if (s.wstb) begin
					n.ctime = s.wdata[arsq_pkg::CT_LSB +: arsq_pkg::CT_W];
				end
			end else if (!arsq_pkg::reg_hit(s.awaddr, arsq_pkg::IDX_RES_LO) &&
			             !arsq_pkg::reg_hit(s.awaddr, arsq_pkg::IDX_RES_HI)) begin
				n.bresp = arsq_pkg::RESP_SLVERR;
			end
		end

		if (s.rvalid && I_RREADY) begin
			n.rvalid = 1'b0;
		end
		// Read side effects act at the address handshake, not when the data leaves.
		if (I_ARVALID && s.arrdy) begin
			n.rvalid = 1'b1;
			n.rresp = arsq_pkg::RESP_OKAY;
			n.rdata = '0;
			if (arsq_pkg::reg_hit(I_ARADDR, arsq_pkg::IDX_CTRL1)) begin
				n.rdata = ctrl1_image(s);
			end else if (arsq_pkg::reg_hit(I_ARADDR, arsq_pkg::IDX_CTRL2)) begin
				n.rdata = ctrl2_image(s);
			end else if (arsq_pkg::reg_hit(I_ARADDR, arsq_pkg::IDX_RES_LO)) begin
				n.rdata = result_image(s.res, 1'h0);
				lo_rd = 1'b1;
			end else if (arsq_pkg::reg_hit(I_ARADDR, arsq_pkg::IDX_RES_HI)) begin
				n.rdata = result_image(s.res, 1'h1);
				hi_rd = 1'b1;
			end else begin
				n.rresp = arsq_pkg::RESP_SLVERR;
			end
		end

		if (hi_rd) begin
			n.end_of_conversion_flag = 1'b0;
			n.low_pend = 1'b0;
		end
		// A low read opens the window in which a completion would tear the pair.
		if (lo_rd) begin
			n.low_pend = 1'b1;
		end

		// A disable write and low power share one path so both clear exactly the same state.
		// low power stop
		stop = dis_wr || I_LOW_POWER;
		mode_ok = mode_runs(s.mode);

		case (s.state)
			arsq_pkg::ST_IDLE: begin
				if (s.start && mode_ok && !stop) begin
					n.state = arsq_pkg::ST_CONV;
					tmr_req.start = 1'b1;
					n.conv_start = 1'b1;
					n.busy = 1'b1;
					n.end_of_conversion_flag = 1'b0;
				end
			end
			arsq_pkg::ST_CONV: begin
				if (tmr_done) begin
					if (!s.low_pend) begin
						n.res = I_CONV_DATA;
						n.end_of_conversion_flag = 1'b1;
						n.irq = 1'b1;
					end
					// The mode at completion decides whether another conversion follows.
					// repeat keeps converting
					if (s.mode == arsq_pkg::MODE_REPEAT) begin
						tmr_req.start = 1'b1;
						n.conv_start = 1'b1;
					end else begin
						n.state = arsq_pkg::ST_IDLE;
						n.busy = 1'b0;
					end
				end
			end
			// An illegal state code falls back to idle rather than locking up.
			default: begin
				n.state = arsq_pkg::ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// A completion in the same cycle as a stop is dropped along with the partial result.
		// forced stop
		if (stop) begin
			n.state = arsq_pkg::ST_IDLE;
			tmr_req.start = 1'b0;
			tmr_req.abort = 1'b1;
			n.conv_start = 1'b0;
			n.conv_abort = s.busy;
			n.irq = 1'b0;
			n.busy = 1'b0;
			n.end_of_conversion_flag = 1'b0;
			n.low_pend = 1'b0;
			n.res = '0;
		end

		// Readiness follows the next state, so a channel reopens the cycle after its response is taken.
		n.awrdy = !n.aw_got && !n.bvalid;
		n.wrdy = !n.w_got && !n.bvalid;
		n.arrdy = !n.rvalid;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			s <= RESET_STATE;
		end else begin
			s <= n;
		end
	end

	// Every output is a register field, so nothing combinational reaches a pin.
	assign O_AWREADY = s.awrdy;
	assign O_WREADY = s.wrdy;
	assign O_BRESP = s.bresp;
	assign O_BVALID = s.bvalid;
	assign O_ARREADY = s.arrdy;
	assign O_RDATA = s.rdata;
	assign O_RRESP = s.rresp;
	assign O_RVALID = s.rvalid;
	assign O_CHANNEL_SEL = s.chan;
	assign O_AIN_EN = s.ain_en;
	assign O_CONV_BUSY = s.busy;
	assign O_CONV_START = s.conv_start;
	assign O_CONV_ABORT = s.conv_abort;
	assign O_DONE_IRQ = s.irq;
endmodule : arsq_top

// file: sim/arsq_core_model.sv
// Analog core stand-in that returns one channel-tagged sample per conversion.
`timescale 1ns/100ps
module arsq_core_model (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_start,
	input  wire logic                      i_busy,
	input  wire logic [arsq_pkg::CH_W-1:0] i_chan,
	output logic [9:0]                     o_data
);
	logic [9:0] val_q;
	// Outside a conversion the lines show the inverse, so a stale capture cannot look right.
	assign o_data = i_busy ? val_q : ~val_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			val_q <= 10'h000;
		end else if (i_start) begin
			val_q <= {i_chan, val_q[5:0] + 6'h01};
		end
	end
endmodule : arsq_core_model

// file: sim/arsq_properties.sv
// Port-level conversion timing properties of the converter sequencer.
`timescale 1ns/100ps
module arsq_properties (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_LOW_POWER,
	input wire logic O_CONV_BUSY,
	input wire logic O_CONV_START,
	input wire logic O_CONV_ABORT,
	input wire logic O_DONE_IRQ
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	a_start_sets_busy: assert property (O_CONV_START |-> O_CONV_BUSY)
		else $error("busy low during a start pulse");
	a_start_one_pulse: assert property (O_CONV_START |=> !O_CONV_START)
		else $error("start pulse longer than one cycle");
	a_done_after_busy: assert property (O_DONE_IRQ |-> $past(O_CONV_BUSY) ##1 !O_DONE_IRQ)
		else $error("done pulse without a running conversion");
	a_min_conv_time: assert property (O_CONV_START |=> !O_DONE_IRQ [*8])
		else $error("conversion finished too early");
	a_repeat_restart: assert property (O_DONE_IRQ && O_CONV_BUSY |-> O_CONV_START)
		else $error("repeat mode did not restart at once");
	a_busy_fall_cause: assert property ($fell(O_CONV_BUSY) |-> O_DONE_IRQ || O_CONV_ABORT)
		else $error("busy dropped without completion or stop");
	a_abort_ends_busy: assert property (O_CONV_ABORT |-> !O_CONV_BUSY && !O_DONE_IRQ)
		else $error("stop left busy set or stored a result");
	a_abort_needs_run: assert property (O_CONV_ABORT |-> $past(O_CONV_BUSY))
		else $error("stop pulse while idle");
	a_low_power_idle: assert property (I_LOW_POWER [*2] |-> !O_CONV_BUSY && !O_DONE_IRQ)
		else $error("activity during low power");
	c_repeat: cover property (O_DONE_IRQ && O_CONV_START);
	c_single: cover property ($fell(O_CONV_BUSY) && O_DONE_IRQ);
	c_abort: cover property (O_CONV_ABORT);
endmodule : arsq_properties

bind arsq_top arsq_properties i_props (.I_CLK(I_CLK), .I_RST(I_RST), .I_LOW_POWER(I_LOW_POWER),
	.O_CONV_BUSY(O_CONV_BUSY), .O_CONV_START(O_CONV_START), .O_CONV_ABORT(O_CONV_ABORT), .O_DONE_IRQ(O_DONE_IRQ));

// file: sim/arsq_test.sv
// Register-level bench for the converter sequencer.
`timescale 1ns/100ps
module arsq_test;
	localparam logic [11:0] A_C1 = {2'h0, arsq_pkg::IDX_CTRL1, 2'h0};
	localparam logic [11:0] A_C2 = {2'h0, arsq_pkg::IDX_CTRL2, 2'h0};
	localparam logic [11:0] A_LO = {2'h0, arsq_pkg::IDX_RES_LO, 2'h0};
	localparam logic [11:0] A_HI = {2'h0, arsq_pkg::IDX_RES_HI, 2'h0};
	localparam int          CYC [6] = '{39, 78, 156, 312, 624, 624};
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic        awv = 1'h0;
	logic        wv = 1'h0;
	logic        arv = 1'h0;
	logic        lp = 1'h0;
	logic        awr, wrr, bv, arr, rv, busy, st, ab, irq, ain;
	logic [1:0]  bresp, rresp;
	logic [3:0]  chan;
	logic [9:0]  cdata;
	logic [31:0] rdata, v, lo;
	int          err_total = 0;
	int          compares = 0;
	int          irqs = 0;
	int          aborts = 0;
	int          n;

	arsq_top i_dut (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wv), .O_WREADY(wrr), .O_BRESP(bresp), .O_BVALID(bv),
		.I_BREADY(1'h1), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rv), .I_RREADY(1'h1), .I_CONV_DATA(cdata), .I_LOW_POWER(lp), .O_CHANNEL_SEL(chan),
		.O_AIN_EN(ain), .O_CONV_BUSY(busy), .O_CONV_START(st), .O_CONV_ABORT(ab), .O_DONE_IRQ(irq));
	arsq_core_model i_core (.i_clk(clk), .i_rst(rst), .i_start(st), .i_busy(busy), .i_chan(chan), .o_data(cdata));

	initial forever #20 clk = ~clk;
	always @(posedge clk) if (irq) irqs++;
	always @(posedge clk) if (ab) aborts++;

	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// Ready-and-bready are held high, so the task only waits for each handshake it needs.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrr) wv <= 1'h0;
		end while (!bv);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arv <= 1'h1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'h0;
		end while (!rv);
		d = rdata;
	endtask : rd

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
		rd(a, v);
		chk(s, v, e);
	endtask : rdc

	task automatic wait_irq;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!irq);
	endtask : wait_irq

	task automatic conclude;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude;
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 4; i++) rdc(A_C1 + 12'(4 * i), 32'h0, "reset value");
		rd(12'h100, v);
		chk("unmapped response", {30'h0, rresp}, {30'h0, arsq_pkg::RESP_SLVERR});
		wr(12'h100, 8'h00);
		chk("unmapped write response", {30'h0, bresp}, {30'h0, arsq_pkg::RESP_SLVERR});
		for (int c = 0; c < 6; c++) begin
			wr(A_C1, 8'h33);
			wr(A_C2, 8'(c));
			wr(A_C1, 8'hb3);
			do @(posedge clk); while (!st);
			wait_irq;
			chk("conversion cycles", n, CYC[c]);
			rdc(A_C1, 32'h33, "start bit");
			rdc(A_C2, 32'h80 | c, "flags after single");
			// both halves read before the next completion
			rdc(A_LO, {24'h0, 2'h3, 6'(c + 1)}, "result low");
			rdc(A_HI, 32'h0, "result high");
			rdc(A_C2, 32'(c), "flag after high read");
		end
		wr(A_C2, 8'h00);
		chk("write response", {30'h0, bresp}, {30'h0, arsq_pkg::RESP_OKAY});
		wr(A_C1, 8'h75);
		wr(A_C1, 8'hf5);
		wait_irq;
		wait_irq;
		chk("repeat period", n, 32'd39);
		chk("channel", {28'h0, chan}, 32'h5);
		chk("input enable", {31'h0, ain}, 32'h1);
		// Low read right after a completion; the next one lands inside the window on purpose.
		rd(A_LO, lo);
		chk("sample channel", lo >> 6, 32'h1);
		n = irqs;
		repeat (45) @(posedge clk);
		chk("suppressed done", irqs, n);
		rdc(A_HI, 32'h1, "high kept");
		rdc(A_LO, lo, "low kept");
		chk("busy in repeat", busy, 32'h1);
		wr(A_C1, 8'h15);
		n = irqs;
		repeat (100) @(posedge clk);
		chk("busy after stop", busy, 32'h0);
		chk("done after stop", irqs, n);
		chk("stop pulses", aborts, 32'h1);
		rdc(A_C2, 32'h0, "flags after stop");
		rdc(A_LO, 32'h0, "low after stop");
		rdc(A_HI, 32'h0, "high after stop");
		wr(A_C1, 8'h95);
		repeat (60) @(posedge clk);
		chk("start while disabled", {busy, irqs[7:0]}, {1'h0, n[7:0]});
		chk("no stop pulse when idle", aborts, 32'h1);
		wr(A_C1, 8'h33);
		wr(A_C1, 8'hb3);
		wait_irq;
		wr(A_C1, 8'hb3);
		rdc(A_C2, 32'h40, "flag on restart");
		wait_irq;
		wr(A_C2, 8'h04);
		wr(A_C1, 8'hb3);
		repeat (10) @(posedge clk);
		lp <= 1'h1;
		repeat (3) @(posedge clk);
		lp <= 1'h0;
		n = irqs;
		repeat (700) @(posedge clk);
		chk("done after low power", irqs, n);
		chk("low power stop pulse", aborts, 32'h2);
		rdc(A_C2, 32'h04, "flags after low power");
		conclude;
	end
endmodule : arsq_test
